// [sapir_consts.vh]
// Constants for the SATA port issue and recovery block
`ifndef SAPIR_CONSTS_VH
`define SAPIR_CONSTS_VH
`define SAPIR_SLOTS 32
`define SAPIR_CMD_SPIN_UP 1
`define SAPIR_CMD_ALP_EN 26
`define SAPIR_CMD_ALP_SLUMBER 27
`define SAPIR_PLL_LOCK 0
`define SAPIR_IS_PIO_SETUP 1
`define SAPIR_IS_IF_FATAL 27
`define SAPIR_TFD_BUSY 7
`define SAPIR_TFD_DRQ 3
`define SAPIR_SERR_LINK_SEQ 23
`define SAPIR_DET_COMRESET 4'h1
`define SAPIR_DET_NONE 4'h0
`define SAPIR_FIFO_W 32
`define SAPIR_FIFO_D 8
`define SAPIR_FIFO_AW 3
`define SAPIR_COMRESET_NS 1000
`define SAPIR_CLK_NS 8
`define SAPIR_COMRESET_CYC ((`SAPIR_COMRESET_NS + `SAPIR_CLK_NS - 1) / `SAPIR_CLK_NS)
`endif

// [sapir_drive.sv]
// Drive model: accepts slot issues, reports completion
module sapir_drive (
  input wire clock_i, valid_i,
  input wire [4:0] slot_i,
  output logic ready_o, done_o,
  output logic [4:0] slot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  bit slow;
  initial {ready_o, done_o, slot_o} = 7'h1F;
  always @(posedge clock_i) if (valid_i) begin
    // Every other slot answers late, so the port must hold
    if (slow) repeat (3) @(posedge clock_i);
    slow = !slow;
    #1 ready_o = 1;
    @(posedge clock_i) slot_o <= slot_i;
    #1 ready_o = 0;
    done_o = 1;
    @(posedge clock_i) #1 done_o = 0;
    slot_o = ~slot_o;
  end
endmodule // sapir_drive

// [sapir_fifo.v]
// Parameterised valid/ready FIFO for the receive data path
module sapir_fifo #(
  parameter W = 32,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clock_i,
  input wire nrst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o,
  input wire flush_i
);
  localparam [AW:0] FULL = D;
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rp_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge clock_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end
  always @(posedge clock_i) begin
    if (!nrst_i || flush_i) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // sapir_fifo

// [sapir_port.v]
// SATA port slot issue, power control, error flags and recovery
`include "sapir_consts.vh"
module sapir_port (
  input wire clock_i,
  input wire nrst_i,
  input wire [31:0] ci_set_i,
  input wire [31:0] port_command_control_i,
  input wire [31:0] serial_pll_control_i,
  input wire [31:0] system_misc_control_i,
  input wire [3:0] detect_init_field_i,
  input wire [31:0] is_clear_i,
  input wire [31:0] serr_clear_i,
  input wire soft_reset_i,
  input wire link_idle_i,
  output reg issue_valid_o,
  output reg [4:0] issue_slot_o,
  input wire issue_ready_i,
  input wire done_valid_i,
  input wire [4:0] done_slot_i,
  input wire pio_setup_fis_i,
  input wire [7:0] fis_status_i,
  input wire fatal_link_err_i,
  input wire link_seq_err_i,
  input wire rx_valid_i,
  output wire rx_ready_o,
  input wire [31:0] rx_data_i,
  output reg rx_valid_o,
  input wire rx_ready_i,
  output reg [31:0] rx_data_o,
  output reg [31:0] port_command_issue_vector_o,
  output reg [31:0] port_interrupt_status_o,
  output reg [31:0] port_taskfile_status_o,
  output reg [31:0] port_serial_error_o,
  output reg spin_up_request_o,
  output reg aggressive_power_enable_o,
  output reg slumber_select_o,
  output reg link_partial_o,
  output reg link_slumber_o,
  output reg pll_lock_o,
  output reg pll_soft_reset_pulse_o,
  output reg comreset_o,
  output reg stalled_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_STALL = 2'd2;
  localparam ST_COMR = 2'd3;
  localparam [15:0] COMR_CYC = `SAPIR_COMRESET_CYC;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [15:0] cnt_q;
  reg [31:0] busy_q;
  reg [4:0] pick;
  reg found;
  integer k;
  wire f_valid;
  wire [31:0] f_data;
  wire f_ready;
  wire drain;
  wire com_start;
  // Lowest pending slot wins; no memory of the last slot issued
  always @* begin
    pick = 5'h00;
    found = 1'b0;
    for (k = 31; k >= 0; k = k - 1) begin
      if (port_command_issue_vector_o[k] && !busy_q[k]) begin
        pick = k[4:0];
        found = 1'b1;
      end
    end
  end
  assign com_start = (detect_init_field_i == `SAPIR_DET_COMRESET);
  // FIFO is drained into a register stage that honours rx_ready_i
  assign drain = f_valid & (~rx_valid_o | rx_ready_i);
  assign f_ready = drain;
  sapir_fifo #(
    .W(`SAPIR_FIFO_W),
    .D(`SAPIR_FIFO_D),
    .AW(`SAPIR_FIFO_AW)
  ) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .in_data_i(rx_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data),
    .flush_i(comreset_o)
  );
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (found && spin_up_request_o) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (issue_ready_i) begin
          st_d = ST_IDLE;
        end
      end
      ST_STALL: begin
        st_d = ST_STALL;
      end
      ST_COMR: begin
        if (cnt_q == 16'h0000) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // PIO setup with busy and DRQ both clear wedges the port, except during COMRESET
    if (st_q != ST_COMR && pio_setup_fis_i &&
        !fis_status_i[`SAPIR_TFD_BUSY] && !fis_status_i[`SAPIR_TFD_DRQ]) begin
      st_d = ST_STALL;
    end
    // Only COMRESET leaves the stall; soft reset does not
    if (com_start) begin
      st_d = ST_COMR;
    end
  end
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      busy_q <= 32'h00000000;
      issue_valid_o <= 1'b0;
      issue_slot_o <= 5'h00;
      rx_valid_o <= 1'b0;
      rx_data_o <= 32'h00000000;
      port_command_issue_vector_o <= 32'h00000000;
      port_interrupt_status_o <= 32'h00000000;
      port_taskfile_status_o <= 32'h0000007F;
      port_serial_error_o <= 32'h00000000;
      spin_up_request_o <= 1'b0;
      aggressive_power_enable_o <= 1'b0;
      slumber_select_o <= 1'b0;
      link_partial_o <= 1'b0;
      link_slumber_o <= 1'b0;
      pll_lock_o <= 1'b0;
      pll_soft_reset_pulse_o <= 1'b0;
      comreset_o <= 1'b0;
      stalled_o <= 1'b0;
    end else begin
      st_q <= st_d;
      stalled_o <= (st_d == ST_STALL);
      comreset_o <= (st_d == ST_COMR);
      if (com_start) begin
        cnt_q <= COMR_CYC - 16'h0001;
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
      spin_up_request_o <= port_command_control_i[`SAPIR_CMD_SPIN_UP];
      aggressive_power_enable_o <=
        port_command_control_i[`SAPIR_CMD_ALP_EN];
      slumber_select_o <= port_command_control_i[`SAPIR_CMD_ALP_SLUMBER];
      // Idle link drops to the selected low-power state
      link_partial_o <= aggressive_power_enable_o & link_idle_i &
        ~slumber_select_o & ~(|port_command_issue_vector_o);
      link_slumber_o <= aggressive_power_enable_o & link_idle_i &
        slumber_select_o & ~(|port_command_issue_vector_o);
      pll_lock_o <= serial_pll_control_i[`SAPIR_PLL_LOCK];
      // The soft reset is passed through; sequencing it is software's job
      pll_soft_reset_pulse_o <= system_misc_control_i[0];
      if (st_d == ST_WAIT && st_q == ST_IDLE) begin
        issue_valid_o <= 1'b1;
        issue_slot_o <= pick;
      end else if (issue_ready_i) begin
        issue_valid_o <= 1'b0;
      end
      if (st_d == ST_COMR || soft_reset_i) begin
        port_command_issue_vector_o <= 32'h00000000;
        busy_q <= 32'h00000000;
        issue_valid_o <= 1'b0;
      end else begin
        // Completion clears the slot; a new set in that cycle wins
        port_command_issue_vector_o <= (port_command_issue_vector_o &
          ~(done_valid_i ? (32'h00000001 << done_slot_i) : 32'h00000000))
          | ci_set_i;
        busy_q <= (busy_q | ((issue_valid_o && issue_ready_i) ?
          (32'h00000001 << issue_slot_o) : 32'h00000000)) &
          ~(done_valid_i ? (32'h00000001 << done_slot_i) : 32'h00000000);
      end
      if (pio_setup_fis_i) begin
        port_taskfile_status_o <= {24'h000000, fis_status_i};
      end
      // Set wins over software clear
      port_interrupt_status_o <= (port_interrupt_status_o & ~is_clear_i) |
        ({31'h00000000, pio_setup_fis_i} << `SAPIR_IS_PIO_SETUP) |
        ({31'h00000000, fatal_link_err_i} << `SAPIR_IS_IF_FATAL);
      port_serial_error_o <= (port_serial_error_o & ~serr_clear_i) |
        ({31'h00000000, link_seq_err_i} << `SAPIR_SERR_LINK_SEQ);
      if (drain) begin
        rx_valid_o <= 1'b1;
        rx_data_o <= f_data;
      end else if (rx_ready_i) begin
        rx_valid_o <= 1'b0;
      end
    end
  end
endmodule // sapir_port

// [sapir_props.sv]
// Checker of the port issue and recovery block
module sapir_props (
  input wire clock_i, nrst_i, soft_reset_i, issue_valid_o,
  input wire issue_ready_i, done_valid_i, pio_setup_fis_i,
  input wire fatal_link_err_i, link_seq_err_i, spin_up_request_o,
  input wire comreset_o, stalled_o,
  input wire [3:0] detect_init_field_i,
  input wire [4:0] issue_slot_o, done_slot_i,
  input wire [7:0] fis_status_i,
  input wire [31:0] ci_set_i, port_command_issue_vector_o,
  input wire [31:0] port_interrupt_status_o, port_serial_error_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Busy and data request both clear
  sequence bad_pio_s;
    pio_setup_fis_i && !fis_status_i[7] && !fis_status_i[3];
  endsequence
  stall_set_a: assert property (bad_pio_s |=> stalled_o)
    else $error("no stall");
  pio_flag_a: assert property (pio_setup_fis_i |=>
    port_interrupt_status_o[1]) else $error("pio flag");
  fatal_flag_a: assert property (fatal_link_err_i |=>
    port_interrupt_status_o[27]) else $error("fatal flag");
  seq_flag_a: assert property (link_seq_err_i |=>
    port_serial_error_o[23]) else $error("seq flag");
  // Soft reset may drop a pending request
  issue_hold_a: assert property (issue_valid_o && !issue_ready_i
    && !soft_reset_i |=> issue_valid_o && $stable(issue_slot_o))
    else $error("issue hold");
  spin_gate_a: assert property ($rose(issue_valid_o) |->
    $past(spin_up_request_o)) else $error("spin gate");
  done_clear_a: assert property (done_valid_i &&
    !ci_set_i[done_slot_i] |=>
    !port_command_issue_vector_o[$past(done_slot_i)]) else $error("done");
  reset_start_a: assert property (detect_init_field_i == 4'h1
    |-> ##[1:2] comreset_o) else $error("comreset");
endmodule // sapir_props
bind sapir_port sapir_props props_u (.*);

// [sapir_tb.sv]
// Self-checking bench for the port issue and recovery block
`include "sapir_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, nrst_i, soft_reset_i, link_idle_i, issue_ready_i;
  logic done_valid_i, pio_setup_fis_i, fatal_link_err_i, link_seq_err_i;
  logic rx_valid_i, rx_ready_i, rx_ready_o, rx_valid_o, issue_valid_o;
  logic spin_up_request_o, aggressive_power_enable_o, slumber_select_o;
  logic link_partial_o, link_slumber_o, pll_lock_o, pll_soft_reset_pulse_o;
  logic comreset_o, stalled_o;
  logic [3:0] detect_init_field_i;
  logic [4:0] issue_slot_o, done_slot_i;
  logic [7:0] fis_status_i;
  logic [31:0] ci_set_i, port_command_control_i, serial_pll_control_i;
  logic [31:0] system_misc_control_i, is_clear_i, serr_clear_i, rx_data_i;
  logic [31:0] rx_data_o, port_command_issue_vector_o;
  logic [31:0] port_interrupt_status_o, port_taskfile_status_o;
  logic [31:0] port_serial_error_o;
  int n_errors, tests_run, cyc, nxt, k, j;
  sapir_port dut_u (.*);
  sapir_drive drv_u (.clock_i(clock_i), .valid_i(issue_valid_o),
    .slot_i(issue_slot_o), .ready_o(issue_ready_i),
    .done_o(done_valid_i), .slot_o(done_slot_i));
  task st(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task ck(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task conclude;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #4 clock_i = ~clock_i;
  end
  // Cut a hang short well beyond the expected run
  always @(posedge clock_i) if (++cyc > 3000) begin
    n_errors++;
    conclude;
  end
  always @(posedge clock_i) if (issue_valid_o && issue_ready_i) begin
    ck("slot", nxt, issue_slot_o);
    nxt++;
  end
  initial begin
    {nrst_i, soft_reset_i, link_idle_i, pio_setup_fis_i, rx_valid_i} = 0;
    {fatal_link_err_i, link_seq_err_i, rx_ready_i, detect_init_field_i} = 0;
    {ci_set_i, port_command_control_i, serial_pll_control_i} = 0;
    {system_misc_control_i, is_clear_i, serr_clear_i, rx_data_i} = 0;
    fis_status_i = 8'h00;
    st(12);
    nrst_i = 1;
    ck("tfd", 32'h7F, port_taskfile_status_o);
    ci_set_i = 32'h1;
    st(6);
    ck("refused", 0, issue_valid_o);
    port_command_control_i = 32'h0C000002;
    ci_set_i = 32'hFFFFFFFF;
    st(1);
    ci_set_i = 32'h0;
    link_idle_i = 1;
    for (k = 0; k < 600 && port_command_issue_vector_o !== 0; k++) st(1);
    ck("order", 32, nxt);
    st(4);
    ck("slumber", 1, link_slumber_o);
    port_command_control_i = 32'h04000002;
    serial_pll_control_i = 32'h1;
    system_misc_control_i = 32'h1;
    st(3);
    ck("partial", 1, link_partial_o);
    ck("lock", 1, pll_lock_o);
    ck("pll rst", 1, pll_soft_reset_pulse_o);
    ck("alp", 1, aggressive_power_enable_o);
    ck("sel", 0, slumber_select_o);
    ck("spin", 1, spin_up_request_o);
    {fatal_link_err_i, link_seq_err_i, pio_setup_fis_i} = 3'h7;
    fis_status_i = 8'h88;
    serial_pll_control_i = 32'h0;
    system_misc_control_i = 32'h0;
    st(1);
    {fatal_link_err_i, link_seq_err_i, pio_setup_fis_i} = 3'h0;
    st(1);
    ck("is", 32'h08000002, port_interrupt_status_o);
    ck("serr", 32'h00800000, port_serial_error_o);
    ck("tfd", 32'h88, port_taskfile_status_o);
    ck("unlock", 0, pll_lock_o | stalled_o);
    // Set wins over a clear in the same cycle
    {is_clear_i, serr_clear_i} = {32'hFFFFFFFF, 32'hFFFFFFFF};
    fis_status_i = 8'h41;
    pio_setup_fis_i = 1;
    st(1);
    {is_clear_i, serr_clear_i, pio_setup_fis_i} = 0;
    st(1);
    ck("is", 32'h2, port_interrupt_status_o);
    ck("serr", 0, port_serial_error_o);
    ck("stall", 1, stalled_o);
    soft_reset_i = 1;
    st(1);
    soft_reset_i = 0;
    st(1);
    ck("stall", 1, stalled_o);
    detect_init_field_i = 4'h1;
    st(1);
    detect_init_field_i = 4'h0;
    st(1);
    ck("comreset", 1, comreset_o);
    st(`SAPIR_COMRESET_CYC + 2);
    ck("recovered", 0, stalled_o | comreset_o);
    // The output register holds one word beyond the eight in the FIFO
    rx_valid_i = 1;
    for (k = 0; k < 9; k++) begin
      rx_data_i = 32'hA0 + k;
      ck("fill", 1, rx_ready_o);
      st(1);
    end
    ck("full", 0, rx_ready_o);
    rx_valid_i = 0;
    rx_ready_i = 1;
    repeat (20) @(posedge clock_i) if (rx_valid_o === 1 && j < 9) begin
      ck("rx", 32'hA0 + j, rx_data_o);
      j++;
    end
    #1 ck("drained", 9, j);
    conclude;
  end
endmodule // tb
